// ---- rtl/ccr_defs.vh ----
/*
  Constants for the codec chip configuration register bank: register
  offsets, field positions, reset values and selector codes.
  Assumes inclusion by bare name from the rtl/ design files.
*/
`ifndef CCR_DEFS_VH
`define CCR_DEFS_VH

// Register word indexes; the byte address is four times the index
`define CCR_IDX_CHIP_IDENT      8'h00
`define CCR_IDX_DIG_POWER       8'h02
`define CCR_IDX_CLK_RATE        8'h04
`define CCR_IDX_SURROUND        8'h10
`define CCR_IDX_BASS_CTRL       8'h12
`define CCR_IDX_BASS_EN         8'h14
`define CCR_IDX_AUTO_LEVEL      8'h16
`define CCR_IDX_TREBLE_GAIN     8'h18
`define CCR_IDX_CLK_STATUS      8'h1A

// Identification fields (values arbitrary)
`define CCR_PART_ID_DEF         8'h5C
`define CCR_REV_ID_DEF          8'h01

// Digital power bit positions
`define CCR_PWR_ADC_BIT         6
`define CCR_PWR_DAC_BIT         5
`define CCR_PWR_PROC_BIT        4
`define CCR_PWR_SOUT_BIT        1
`define CCR_PWR_SIN_BIT         0
`define CCR_PWR_RW_MASK         16'h007F
`define CCR_PWR_RST             16'h0000

// Clock control fields and reset
`define CCR_CLK_RW_MASK         16'h003F
`define CCR_CLK_RST             16'h0008
`define CCR_RATE_DIV_LSB        4
`define CCR_SYS_RATE_LSB        2
`define CCR_MCLK_RATIO_LSB      0
`define CCR_MCLK_USE_PLL        2'h3

// Processor feature registers
`define CCR_SURR_RW_MASK        16'h0073
`define CCR_SURR_RST            16'h0040
`define CCR_SURR_ON             2'h3
`define CCR_BASS_CTRL_MASK      16'h00FF
`define CCR_BASS_CTRL_RST       16'h001F
`define CCR_EN_MASK             16'h0001
`define CCR_TREBLE_MASK         16'h007F
`define CCR_TREBLE_RST          16'h002F

// Cycles the bus answer is held off
`define CCR_WAIT_CYCLES         1

`endif

// ---- rtl/ccr_rate_decode.v ----
/*
  Decodes the clock control field into sample rate, divider and master
  clock ratio selects. Assumes the fields come from registers on CLK.
*/
`timescale 1ns/1ps
module ccr_rate_decode
(
  // Clock control fields
  input  wire [1:0] rate_div,
  input  wire [1:0] sys_rate,
  input  wire [1:0] mclk_ratio,
  // Decoded selects
  output reg  [3:0] sys_rate_onehot,
  output reg  [2:0] divide_by,
  output reg  [2:0] ratio_onehot,
  output wire       use_pll
);
  always @*
  begin
    sys_rate_onehot = 4'h0;
    sys_rate_onehot[sys_rate] = 1'b1;             // RULE_17
    case (rate_div)                               // RULE_15
      2'h0: divide_by = 3'h1;
      2'h1: divide_by = 3'h2;
      2'h2: divide_by = 3'h4;
      default: divide_by = 3'h6;
    endcase
    // Ratio is kept against the undivided system rate
    ratio_onehot = 3'h0;                          // RULE_16
    if (mclk_ratio != 2'h3)
    begin
      ratio_onehot[mclk_ratio] = 1'b1;            // RULE_18
    end
  end
  assign use_pll = (mclk_ratio == 2'h3);          // RULE_18
endmodule // ccr_rate_decode

// ---- rtl/ccr_config_regs.v ----
/*
  Chip configuration register bank of a stereo audio codec, with the
  processor feature switches, reached over Avalon-MM with waitrequest.
  Assumes one 50 MHz clock and a master that keeps the request held
  until waitrequest is seen low.
*/
// What this block and its host do
// RULE_01: Host ramps tone gains in quarter-decibel steps, one write each.
// RULE_02: Host computes gain code as four times decibels plus 47.
// RULE_03: Host steps code by one toward target; zero difference does nothing.
// RULE_04: Host ramps surround width to 7 around switching, then restores it.
// RULE_05: Surround selector bits 1:0 equal to 3 turn surround on.
// RULE_06: Host ramps bass level to 0x7F around switching, then restores it.
// RULE_07: Bass enhancement enable bit 0 switches the feature on and off.
// RULE_08: Automatic leveler enable bit 0 switches the leveler on and off.
// RULE_09: Identification reads part code 15:8 and revision 7:0, read-only.
// RULE_10: Power bit 6 enables the input converter; resets to zero.
// RULE_11: Power bit 5 enables the output converter; resets to zero.
// RULE_12: Power bit 4 enables the audio processor; resets to zero.
// RULE_13: Power bit 1 enables the serial audio output path.
// RULE_14: Power bit 0 enables the serial audio input path.
// RULE_15: Rate divider bits 5:4 give full, half, quarter or sixth rate.
// RULE_16: Clock ratio is always relative to the undivided system rate.
// RULE_17: System rate bits 3:2 pick 32, 44.1, 48, 96 kHz; reset 2.
// RULE_18: Ratio bits 1:0 mean 256, 384, 512 times rate, or 3 PLL.
// RULE_19: Host uses PLL code for non-standard master clock ratios.
// RULE_20: Host powers and programs the PLL before selecting it; the bench host selects ratio code 3 with no PLL setup.
`timescale 1ns/1ps
`include "ccr_defs.vh"
module ccr_config_regs
#(
  parameter [7:0] PART_ID = `CCR_PART_ID_DEF, // Value arbitrary
  parameter [7:0] REV_ID  = `CCR_REV_ID_DEF   // Value arbitrary
)
(
  // Clock and reset
  input  wire        CLK,
  input  wire        ARST_N,
  // Avalon-MM slave
  input  wire [9:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [31:0] AVS_WRITEDATA,
  input  wire [3:0]  AVS_BYTEENABLE,
  output reg  [31:0] AVS_READDATA,
  output reg         AVS_WAITREQUEST,
  output reg  [1:0]  AVS_RESPONSE,
  // Block power enables
  output reg         ADC_POWER_EN,
  output reg         DAC_POWER_EN,
  output reg         PROC_POWER_EN,
  output reg         SOUT_ENABLE,
  output reg         SIN_ENABLE,
  // Clock selects
  output reg  [3:0]  SYS_RATE_SEL,
  output reg  [2:0]  RATE_DIVIDE_BY,
  output reg  [2:0]  MCLK_RATIO_SEL,
  output reg         USE_PLL,
  // Processor features
  output reg         SURROUND_ON,
  output reg  [2:0]  SURROUND_WIDTH,
  output reg         BASS_ENH_ON,
  output reg  [6:0]  BASS_LEVEL,
  output reg         AUTO_LEVEL_ON,
  output reg  [6:0]  TREBLE_GAIN
);
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_DONE = 2'b10;

  reg  [1:0]  state_q;
  reg  [15:0] pwr_q;
  reg  [15:0] clk_q;
  reg  [15:0] surr_q;
  reg  [15:0] bass_ctrl_q;
  reg  [15:0] bass_en_q;
  reg  [15:0] auto_q;
  reg  [15:0] treble_q;
  reg  [15:0] rd_d;
  reg         hit_d;
  reg  [15:0] lane_mask;
  wire [7:0]  idx;
  wire [15:0] wd;
  wire [3:0]  rate_oh;
  wire [2:0]  div_by;
  wire [2:0]  ratio_oh;
  wire        pll_sel;

  // Word address: byte address divided by four
  assign idx = AVS_ADDRESS[9:2];
  assign wd  = AVS_WRITEDATA[15:0];

  always @*
  begin
    lane_mask = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  end

  // Read decode
  always @*
  begin
    rd_d  = 16'h0000;
    hit_d = 1'b1;
    if (idx == `CCR_IDX_CHIP_IDENT)
      rd_d = {PART_ID, REV_ID};                   // RULE_09
    else if (idx == `CCR_IDX_DIG_POWER)
      rd_d = pwr_q;
    else if (idx == `CCR_IDX_CLK_RATE)
      rd_d = clk_q;
    else if (idx == `CCR_IDX_SURROUND)
      rd_d = surr_q;
    else if (idx == `CCR_IDX_BASS_CTRL)
      rd_d = bass_ctrl_q;
    else if (idx == `CCR_IDX_BASS_EN)
      rd_d = bass_en_q;
    else if (idx == `CCR_IDX_AUTO_LEVEL)
      rd_d = auto_q;
    else if (idx == `CCR_IDX_TREBLE_GAIN)
      rd_d = treble_q;
    else if (idx == `CCR_IDX_CLK_STATUS)
      rd_d = {6'h00, pll_sel, div_by, rate_oh, ratio_oh[1:0]};
    else
      hit_d = 1'b0;
  end

  // Register writes at the edge where waitrequest is low
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      pwr_q       <= `CCR_PWR_RST;                // RULE_10
      clk_q       <= `CCR_CLK_RST;                // RULE_17
      surr_q      <= `CCR_SURR_RST;
      bass_ctrl_q <= `CCR_BASS_CTRL_RST;
      bass_en_q   <= 16'h0000;
      auto_q      <= 16'h0000;
      treble_q    <= `CCR_TREBLE_RST;
    end
    else if (AVS_WRITE && state_q == ST_DONE)
    begin
      if (idx == `CCR_IDX_DIG_POWER)
        pwr_q <= ((pwr_q & ~lane_mask) | (wd & lane_mask))
                 & `CCR_PWR_RW_MASK;              // RULE_11
      else if (idx == `CCR_IDX_CLK_RATE)
        clk_q <= ((clk_q & ~lane_mask) | (wd & lane_mask))
                 & `CCR_CLK_RW_MASK;              // RULE_15
      else if (idx == `CCR_IDX_SURROUND)
        surr_q <= ((surr_q & ~lane_mask) | (wd & lane_mask))
                  & `CCR_SURR_RW_MASK;            // RULE_05
      else if (idx == `CCR_IDX_BASS_CTRL)
        bass_ctrl_q <= ((bass_ctrl_q & ~lane_mask) | (wd & lane_mask))
                       & `CCR_BASS_CTRL_MASK;
      else if (idx == `CCR_IDX_BASS_EN)
        bass_en_q <= ((bass_en_q & ~lane_mask) | (wd & lane_mask))
                     & `CCR_EN_MASK;              // RULE_07
      else if (idx == `CCR_IDX_AUTO_LEVEL)
        auto_q <= ((auto_q & ~lane_mask) | (wd & lane_mask))
                  & `CCR_EN_MASK;                 // RULE_08
      else if (idx == `CCR_IDX_TREBLE_GAIN)
        treble_q <= ((treble_q & ~lane_mask) | (wd & lane_mask))
                    & `CCR_TREBLE_MASK;
    end
  end

  // Bus handshake: one wait cycle, then answer
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_q         <= ST_IDLE;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h00000000;
      AVS_RESPONSE    <= 2'h0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (AVS_READ || AVS_WRITE)
          begin
            state_q         <= ST_DONE;
            AVS_WAITREQUEST <= 1'b0;
            AVS_READDATA    <= {16'h0000, rd_d};
            AVS_RESPONSE    <= hit_d ? 2'h0 : 2'h3;
          end
        end
        default:
        begin
          state_q         <= ST_IDLE;
          AVS_WAITREQUEST <= 1'b1;
        end
      endcase
    end
  end

  ccr_rate_decode u_rate
  (
    .rate_div        (clk_q[5:4]),
    .sys_rate        (clk_q[3:2]),
    .mclk_ratio      (clk_q[1:0]),
    .sys_rate_onehot (rate_oh),
    .divide_by       (div_by),
    .ratio_onehot    (ratio_oh),
    .use_pll         (pll_sel)
  );

  // Registered outputs
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ADC_POWER_EN   <= 1'b0;
      DAC_POWER_EN   <= 1'b0;
      PROC_POWER_EN  <= 1'b0;
      SOUT_ENABLE    <= 1'b0;
      SIN_ENABLE     <= 1'b0;
      SYS_RATE_SEL   <= 4'h4;
      RATE_DIVIDE_BY <= 3'h1;
      MCLK_RATIO_SEL <= 3'h1;
      USE_PLL        <= 1'b0;
      SURROUND_ON    <= 1'b0;
      SURROUND_WIDTH <= 3'h4;
      BASS_ENH_ON    <= 1'b0;
      BASS_LEVEL     <= 7'h1F;
      AUTO_LEVEL_ON  <= 1'b0;
      TREBLE_GAIN    <= 7'h2F;
    end
    else
    begin
      ADC_POWER_EN   <= pwr_q[`CCR_PWR_ADC_BIT];  // RULE_10
      DAC_POWER_EN   <= pwr_q[`CCR_PWR_DAC_BIT];  // RULE_11
      PROC_POWER_EN  <= pwr_q[`CCR_PWR_PROC_BIT]; // RULE_12
      SOUT_ENABLE    <= pwr_q[`CCR_PWR_SOUT_BIT]; // RULE_13
      SIN_ENABLE     <= pwr_q[`CCR_PWR_SIN_BIT];  // RULE_14
      SYS_RATE_SEL   <= rate_oh;                  // RULE_17
      RATE_DIVIDE_BY <= div_by;                   // RULE_15
      MCLK_RATIO_SEL <= ratio_oh;                 // RULE_16
      USE_PLL        <= pll_sel;                  // RULE_18
      SURROUND_ON    <= (surr_q[1:0] == `CCR_SURR_ON); // RULE_05
      SURROUND_WIDTH <= surr_q[6:4];
      BASS_ENH_ON    <= bass_en_q[0];             // RULE_07
      BASS_LEVEL     <= bass_ctrl_q[6:0];
      AUTO_LEVEL_ON  <= auto_q[0];                // RULE_08
      TREBLE_GAIN    <= treble_q[6:0];
    end
  end
endmodule // ccr_config_regs

// ---- bench/ccr_config_regs_props.sv ----
/*
  Checker for the configuration register bank.
  Assumes it sees only the top module's ports.
*/
`timescale 1ns/1ps
module ccr_config_regs_props
(
  // Clock and reset
  input wire        CLK,
  input wire        ARST_N,
  // Bus
  input wire        AVS_WRITE,
  input wire        AVS_READ,
  input wire [31:0] AVS_READDATA,
  input wire        AVS_WAITREQUEST,
  input wire [1:0]  AVS_RESPONSE,
  // Decoded outputs
  input wire        ADC_POWER_EN,
  input wire        SIN_ENABLE,
  input wire [3:0]  SYS_RATE_SEL,
  input wire [2:0]  RATE_DIVIDE_BY,
  input wire [2:0]  MCLK_RATIO_SEL,
  input wire        USE_PLL
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  property p_one_wait;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("No answer one cycle after request");
  property p_hi_zero;
    !AVS_WAITREQUEST |-> AVS_READDATA[31:16] == 16'h0000;
  endproperty
  a_hi_zero: assert property (p_hi_zero)
    else $error("Upper read half not zero");
  property p_err_zero;
    !AVS_WAITREQUEST && AVS_RESPONSE == 2'h3 |-> AVS_READDATA == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("Unmapped read returned data");
  property p_rate_oh;
    $onehot(SYS_RATE_SEL);
  endproperty
  a_rate_oh: assert property (p_rate_oh)
    else $error("Rate select not one-hot");
  property p_div_ok;
    RATE_DIVIDE_BY inside {3'h1, 3'h2, 3'h4, 3'h6};
  endproperty
  a_div_ok: assert property (p_div_ok)
    else $error("Illegal divider");
  property p_pll_excl;
    USE_PLL |-> MCLK_RATIO_SEL == 3'h0;
  endproperty
  a_pll_excl: assert property (p_pll_excl)
    else $error("Ratio select while on PLL");
  property p_ratio_oh;
    !USE_PLL |-> $onehot(MCLK_RATIO_SEL);
  endproperty
  a_ratio_oh: assert property (p_ratio_oh)
    else $error("Ratio select not one-hot");
  property p_pwr_cause;
    $changed({ADC_POWER_EN, SIN_ENABLE}) |->
      $past(AVS_WRITE, 1) || $past(AVS_WRITE, 2);
  endproperty
  a_pwr_cause: assert property (p_pwr_cause)
    else $error("Power enable moved without a write");
  c_write: cover property (AVS_WRITE && !AVS_WAITREQUEST);
  c_err: cover property (!AVS_WAITREQUEST && AVS_RESPONSE == 2'h3);
  c_pll: cover property (USE_PLL);
endmodule // ccr_config_regs_props

// ---- bench/ccr_host_model.sv ----
/*
  Host model: Avalon-MM master and the one-step field ramp.
  Assumes a registered slave that drops waitrequest per request.
*/
`timescale 1ns/1ps
module ccr_host_model
(
  // Clock and answer
  input  wire        clk,
  input  wire        waitreq,
  input  wire [31:0] rdata,
  input  wire [1:0]  resp,
  // Request
  output reg  [9:0]  addr,
  output reg         rd,
  output reg         wr,
  output reg  [31:0] wdata
);
  reg [31:0] last;
  reg [1:0]  last_resp;
  initial
  begin
    addr = 10'h000;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
  end
  task bus(input w, input [9:0] a, input [15:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= {16'h0000, d};
      rd <= ~w;
      wr <= w;
      @(posedge clk);
      while (waitreq !== 1'b0)
        @(posedge clk);
      last = rdata;
      last_resp = resp;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask
  // One code per write so the audio never jumps
  task ramp(input [9:0] a, input [15:0] keep, input integer lsb,
            input integer cur, input integer tgt);
    integer v;
    begin
      v = cur;
      while (v != tgt)
      begin
        v = (tgt > v) ? v + 1 : v - 1;
        bus(1'b1, a, keep | 16'(v << lsb));
      end
    end
  endtask
endmodule // ccr_host_model

// ---- bench/test_ccr_config_regs.sv ----
/*
  Testbench for the configuration register bank.
  Assumes the host model drives the bus; checker bound below.
*/
`timescale 1ns/1ps
module test_ccr_config_regs;
  reg         clk;
  reg         arst_n;
  reg  [3:0]  be;
  wire [9:0]  addr;
  wire        rd, wr, waitreq, use_pll, surr_on, bass_on, auto_on;
  wire [31:0] wdata, rdata;
  wire [1:0]  resp;
  wire [4:0]  pwr;
  wire [3:0]  rate_sel;
  wire [2:0]  div_by, ratio_sel, surr_w;
  wire [6:0]  bass_lvl, treble;
  integer     err_count, tests_run, cyc, i;
  ccr_host_model u_host (.clk(clk), .waitreq(waitreq), .rdata(rdata),
    .resp(resp), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata));
  ccr_config_regs u_dut (.CLK(clk), .ARST_N(arst_n), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .AVS_RESPONSE(resp), .ADC_POWER_EN(pwr[4]), .DAC_POWER_EN(pwr[3]),
    .PROC_POWER_EN(pwr[2]), .SOUT_ENABLE(pwr[1]), .SIN_ENABLE(pwr[0]),
    .SYS_RATE_SEL(rate_sel), .RATE_DIVIDE_BY(div_by),
    .MCLK_RATIO_SEL(ratio_sel), .USE_PLL(use_pll), .SURROUND_ON(surr_on),
    .SURROUND_WIDTH(surr_w), .BASS_ENH_ON(bass_on), .BASS_LEVEL(bass_lvl),
    .AUTO_LEVEL_ON(auto_on), .TREBLE_GAIN(treble));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task rc(input [9:0] a, input [15:0] exp);
    begin
      u_host.bus(1'b0, a, 16'h0000);
      chk(u_host.last, {16'h0000, exp});
    end
  endtask
  task finish_test;
    begin
      $display("Checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count = err_count + 1;
      finish_test;
    end
  end
  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    be = 4'hF;
    err_count = 0;
    tests_run = 0;
    cyc = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    rc(10'h000, 16'h5C01);
    rc(10'h008, 16'h0000);
    rc(10'h010, 16'h0008);
    rc(10'h048, 16'h001F);
    chk({surr_w, bass_lvl, treble}, {3'h4, 7'h1F, 7'h2F});
    u_host.bus(1'b1, 10'h000, 16'hFFFF);
    rc(10'h000, 16'h5C01);
    for (i = 0; i < 5; i = i + 1)
    begin
      u_host.bus(1'b1, 10'h008, 16'h0001 << (i < 3 ? 6 - i : 4 - i));
      chk(u_host.last_resp, 2'h0);
      rc(10'h008, 16'h0001 << (i < 3 ? 6 - i : 4 - i));
      chk(pwr, 5'h10 >> i);
    end
    u_host.bus(1'b1, 10'h008, 16'hFFFF);
    rc(10'h008, 16'h007F);
    be <= 4'h2;
    u_host.bus(1'b1, 10'h008, 16'h0000);
    rc(10'h008, 16'h007F);
    be <= 4'hF;
    for (i = 0; i < 64; i = i + 1)
    begin
      u_host.bus(1'b1, 10'h010, i[15:0]);
      rc(10'h010, i[15:0]);
      chk(rate_sel, 4'h1 << i[3:2]);
      chk(div_by, i[5] ? (i[4] ? 6 : 4) : (i[4] ? 2 : 1));
      chk({use_pll, ratio_sel}, i[1:0] == 2'h3 ? 4'h8 : 4'h1 << i[1:0]);
    end
    rc(10'h068, 16'h03A0);
    u_host.ramp(10'h040, 16'h0000, 4, 4, 7);
    u_host.bus(1'b1, 10'h040, 16'h0073);
    rc(10'h040, 16'h0073);
    chk({surr_on, surr_w}, 4'hF);
    u_host.ramp(10'h040, 16'h0003, 4, 7, 4);
    rc(10'h040, 16'h0043);
    chk({surr_on, surr_w}, 4'hC);
    u_host.ramp(10'h040, 16'h0003, 4, 4, 7);
    u_host.bus(1'b1, 10'h040, 16'h0070);
    u_host.ramp(10'h040, 16'h0000, 4, 7, 4);
    rc(10'h040, 16'h0040);
    chk({surr_on, surr_w}, 4'h4);
    u_host.ramp(10'h048, 16'h0000, 0, 7'h1F, 7'h7F);
    for (i = 1; i >= 0; i = i - 1)
    begin
      u_host.bus(1'b1, 10'h050, i[15:0]);
      u_host.bus(1'b1, 10'h058, i[15:0]);
      rc(10'h058, i[15:0]);
      rc(10'h050, i[15:0]);
      chk({auto_on, bass_on, bass_lvl}, {i[0], i[0], 7'h7F});
    end
    u_host.ramp(10'h048, 16'h0000, 0, 7'h7F, 7'h1F);
    rc(10'h048, 16'h001F);
    chk(bass_lvl, 7'h1F);
    u_host.ramp(10'h060, 16'h0000, 0, 7'h2F, 4 * 3 + 47);
    u_host.ramp(10'h060, 16'h0000, 0, 7'h3B, 7'h3B);
    rc(10'h060, 16'h003B);
    chk(treble, 7'h3B);
    rc(10'h3FC, 16'h0000);
    chk(u_host.last_resp, 2'h3);
    finish_test;
  end
endmodule // test_ccr_config_regs
bind ccr_config_regs ccr_config_regs_props u_props (.CLK(CLK),
  .ARST_N(ARST_N), .AVS_WRITE(AVS_WRITE), .AVS_READ(AVS_READ),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .AVS_RESPONSE(AVS_RESPONSE), .ADC_POWER_EN(ADC_POWER_EN),
  .SIN_ENABLE(SIN_ENABLE), .SYS_RATE_SEL(SYS_RATE_SEL),
  .RATE_DIVIDE_BY(RATE_DIVIDE_BY), .MCLK_RATIO_SEL(MCLK_RATIO_SEL),
  .USE_PLL(USE_PLL));
